// file: core/semm_defs.vh
// constants for the supply event and mode manager
`ifndef SEMM_DEFS_VH
`define SEMM_DEFS_VH
`define SEMM_A_TEMP_RES    8'hd7
`define SEMM_A_BAT_RES     8'hdf
`define SEMM_A_DCIN_RES    8'hef
`define SEMM_A_DELTA       8'hf3
`define SEMM_A_PERIPHERAL_CONFIG      8'hf4
`define SEMM_A_SWCFG       8'hf5
`define SEMM_A_FLAGS       8'hf8
`define SEMM_A_STRB        8'hf9
`define SEMM_A_BATTH       8'hfa
`define SEMM_A_SCR1        8'hfb
`define SEMM_A_SCR2        8'hfc
`define SEMM_A_SCR3        8'hfd
`define SEMM_A_SCR4        8'hfe
`define SEMM_A_ENABLE      8'hec
`define SEMM_B_DCIN        0
`define SEMM_B_SAG         5
`define SEMM_B_SRC         6
`define SEMM_SEL_DCIN      2'h1
`define SEMM_SEL_MAIN      2'h0
`define SEMM_CLK_MHZ       100
`define SEMM_T1_NS         10
`define SEMM_T2_NS         10
`define SEMM_T3_MS         30
`define SEMM_T4_MS         130
`define SEMM_T1_CYC        ((`SEMM_T1_NS * `SEMM_CLK_MHZ + 999) / 1000)
`define SEMM_T2_CYC        ((`SEMM_T2_NS * `SEMM_CLK_MHZ + 999) / 1000)
`define SEMM_T3_CYC        (`SEMM_T3_MS * 1000 * `SEMM_CLK_MHZ)
`define SEMM_T4_CYC        (`SEMM_T4_MS * 1000 * `SEMM_CLK_MHZ)
`define SEMM_ZERO8         8'h00
`define SEMM_RST_PERIPHERAL_CONFIG    8'h40
`endif

// file: core/semm_supply_manager.v
// supply event flags, switchover timing and power mode sequencing
// Notes on behaviour
// - set dc-input-low flag once each time comparator reports dc input below threshold.
// - dc-input-low reaches shared interrupt only when its enable bit set.
// - set line dip flag when line dip detector reports enough low cycles.
// - line dip reaches shared interrupt only when its enable bit set.
// - dc-input-low flag rises at least 10 ns after comparator trip.
// - main-supply switchover at least 10 ns after main supply falls low.
// - dc-input switchover 30 ms after dc input falls, when selected.
// - restore to main supply 130 ms after all enabled restore conditions hold.
// - normal mode runs from main supply; core clock defaults to 1.024 MHz.
// - battery mode keeps core and logic on, metering front end off.
// - leave battery mode when main supply good and power-down bit clear.
// - sleep powers down core; every exit restarts at reset vector.
// - sleep peripherals run per enables written while core was awake.
// - sleep lasts until a qualifying wake-up event arrives.
// - four scratch registers keep contents across sleep.
// - retained configuration and result registers survive sleep.
// - event flags stay latched; software clears a flag writing 0.
// - dc-input switchover only when switchover select equals 01.
// - shared interrupt reaches core only with global enable set.
`timescale 1ns/1ps
`default_nettype none
`include "semm_defs.vh"
module semm_supply_manager #(
    parameter [31:0] T3_CYCLES = `SEMM_T3_CYC,
    parameter [31:0] T4_CYCLES = `SEMM_T4_CYC
) (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire [7:0] sfrAddr,
    input  wire [7:0] sfrWrData,
    input  wire       sfrWrEn,
    input  wire       sfrRdEn,
    output reg  [7:0] sfrRdData,
    input  wire       dcInputLow,
    input  wire       mainSupplyLow,
    input  wire       lineDipEvent,
    input  wire       frontEndPowerDown,
    input  wire       supplyIrqGlobalEnable,
    input  wire       sleepRequest,
    input  wire       wakeEvent,
    input  wire [7:0] tempResultIn,
    input  wire [7:0] batResultIn,
    input  wire [7:0] dcinResultIn,
    input  wire       resultStrobe,
    output reg        supplyIrq,
    output reg        supplySourceMain,
    output reg        frontEndEnable,
    output reg        coreEnable,
    output reg        coreRestart,
    output reg        coreClkDefault,
    output reg  [2:0] modeState,
    output reg  [3:0] sleepPeriphEnable
);
    localparam [2:0] ST_NORMAL  = 3'h1;
    localparam [2:0] ST_BATTERY = 3'h2;
    localparam [2:0] ST_SLEEP   = 3'h4;
    localparam [31:0] T1_CYC = `SEMM_T1_CYC;
    localparam [31:0] T2_CYC = `SEMM_T2_CYC;

    reg [7:0]  flags_q, enable_q, swcfg_q, periphCfg_q, delta_q;
    reg [7:0]  strb_q, batth_q, tempRes_q, batRes_q, dcinRes_q;
    reg [7:0]  scratch_q [0:3];
    reg [2:0]  state_q;
    reg        dcinLowSeen_q;

    wire       dcinTrip;
    wire       mainTrip;
    wire       swDcinAt;
    wire       restoreAt;

    wire       selDcin    = (swcfg_q[1:0] == `SEMM_SEL_DCIN);
    wire       selMain    = (swcfg_q[1:0] == `SEMM_SEL_MAIN);
    wire       swEnabled  = selDcin | selMain;
    wire       wrFlags    = sfrWrEn && (sfrAddr == `SEMM_A_FLAGS);
    wire       dcinSwTrip = selDcin && swDcinAt;
    // restore needs dc input good too when dc-input switchover selected
    wire       restoreOk  = !mainSupplyLow && !(selDcin && dcInputLow);
    wire       restoreDone = restoreOk && restoreAt;
    wire       restoreClr = !restoreOk || (state_q == ST_NORMAL);
    wire       goBattery  = swEnabled && (mainTrip || dcinSwTrip);
    // a held power-down keeps sleep even once supply is back
    wire       leaveSleep = (restoreDone && !frontEndPowerDown) || wakeEvent;
    wire [7:0] flagsSet;
    assign flagsSet = {2'b00, lineDipEvent, 4'b0000,
                       dcinTrip && !dcinLowSeen_q};

    // filter and delay counters; each clears while its condition is absent
    semm_sat_counter #(
        .LIMIT(T1_CYC)
    ) u_dcin_filter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (!dcInputLow),
        .atLimit (dcinTrip)
    );

    semm_sat_counter #(
        .LIMIT(T2_CYC)
    ) u_main_filter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (!mainSupplyLow),
        .atLimit (mainTrip)
    );

    semm_sat_counter #(
        .LIMIT(T3_CYCLES)
    ) u_dcin_switch (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (!dcInputLow),
        .atLimit (swDcinAt)
    );

    semm_sat_counter #(
        .LIMIT(T4_CYCLES)
    ) u_restore_delay (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (restoreClr),
        .atLimit (restoreAt)
    );

    // one flag set per fall below threshold
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dcinLowSeen_q <= 1'b0;
        end else begin
            dcinLowSeen_q <= dcinTrip;
        end
    end

    // mode sequencer
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_NORMAL;
        end else begin
            case (state_q)
                ST_NORMAL: begin
                    if (goBattery)
                        state_q <= ST_BATTERY;
                end
                ST_BATTERY: begin
                    if (restoreDone && !frontEndPowerDown)
                        state_q <= ST_NORMAL;
                    else if (sleepRequest)
                        state_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    // supply restore is a wake source, masked while front end power-down is held
                    if (restoreDone && !frontEndPowerDown)
                        state_q <= ST_NORMAL;
                    else if (wakeEvent)
                        state_q <= ST_BATTERY;
                end
                default: state_q <= ST_NORMAL;
            endcase
        end
    end

    // event flags; set wins over a same-cycle software clear by writing 0
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `SEMM_ZERO8;
        end else begin
            flags_q <= (wrFlags ? (flags_q & sfrWrData) : flags_q)
                       | flagsSet;
        end
    end

    // only the core writes; it is off in sleep so retained state holds
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q     <= `SEMM_ZERO8;
            swcfg_q      <= `SEMM_ZERO8;
            periphCfg_q  <= `SEMM_ZERO8;
            delta_q      <= `SEMM_ZERO8;
            strb_q       <= `SEMM_ZERO8;
            batth_q      <= `SEMM_ZERO8;
            scratch_q[0] <= `SEMM_ZERO8;
            scratch_q[1] <= `SEMM_ZERO8;
            scratch_q[2] <= `SEMM_ZERO8;
            scratch_q[3] <= `SEMM_ZERO8;
        end else if (sfrWrEn && state_q != ST_SLEEP) begin
            case (sfrAddr)
                `SEMM_A_ENABLE: enable_q     <= sfrWrData;
                `SEMM_A_SWCFG:  swcfg_q      <= sfrWrData;
                `SEMM_A_PERIPHERAL_CONFIG: periphCfg_q  <= sfrWrData;
                `SEMM_A_DELTA:  delta_q      <= sfrWrData;
                `SEMM_A_STRB:   strb_q       <= sfrWrData;
                `SEMM_A_BATTH:  batth_q      <= sfrWrData;
                `SEMM_A_SCR1:   scratch_q[0] <= sfrWrData;
                `SEMM_A_SCR2:   scratch_q[1] <= sfrWrData;
                `SEMM_A_SCR3:   scratch_q[2] <= sfrWrData;
                `SEMM_A_SCR4:   scratch_q[3] <= sfrWrData;
                default: ;
            endcase
        end
    end

    // converter results load on their strobe only, so they survive sleep
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tempRes_q <= `SEMM_ZERO8;
            batRes_q  <= `SEMM_ZERO8;
            dcinRes_q <= `SEMM_ZERO8;
        end else if (resultStrobe) begin
            tempRes_q <= tempResultIn;
            batRes_q  <= batResultIn;
            dcinRes_q <= dcinResultIn;
        end
    end

    // read data holds until the next read
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdData <= `SEMM_ZERO8;
        end else if (sfrRdEn) begin
            case (sfrAddr)
                `SEMM_A_TEMP_RES: sfrRdData <= tempRes_q;
                `SEMM_A_BAT_RES:  sfrRdData <= batRes_q;
                `SEMM_A_DCIN_RES: sfrRdData <= dcinRes_q;
                `SEMM_A_DELTA:    sfrRdData <= delta_q;
                `SEMM_A_PERIPHERAL_CONFIG:   sfrRdData <= {periphCfg_q[7],
                                    state_q == ST_NORMAL,
                                    periphCfg_q[5:0]};
                `SEMM_A_SWCFG:    sfrRdData <= swcfg_q;
                `SEMM_A_FLAGS:    sfrRdData <= flags_q;
                `SEMM_A_ENABLE:   sfrRdData <= enable_q;
                `SEMM_A_STRB:     sfrRdData <= strb_q;
                `SEMM_A_BATTH:    sfrRdData <= batth_q;
                `SEMM_A_SCR1:     sfrRdData <= scratch_q[0];
                `SEMM_A_SCR2:     sfrRdData <= scratch_q[1];
                `SEMM_A_SCR3:     sfrRdData <= scratch_q[2];
                `SEMM_A_SCR4:     sfrRdData <= scratch_q[3];
                default:          sfrRdData <= `SEMM_ZERO8;
            endcase
        end
    end

    // status outputs, all registered
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            supplyIrq         <= 1'b0;
            supplySourceMain  <= 1'b1;
            frontEndEnable    <= 1'b1;
            coreEnable        <= 1'b1;
            coreRestart       <= 1'b0;
            coreClkDefault    <= 1'b1;
            modeState         <= ST_NORMAL;
            sleepPeriphEnable <= 4'h0;
        end else begin
            supplyIrq <= supplyIrqGlobalEnable &&
                ((flags_q[`SEMM_B_DCIN] && enable_q[`SEMM_B_DCIN]) ||
                 (flags_q[`SEMM_B_SAG] && enable_q[`SEMM_B_SAG]));
            supplySourceMain <= (state_q == ST_NORMAL);
            frontEndEnable   <= (state_q == ST_NORMAL);
            coreEnable       <= (state_q != ST_SLEEP);
            // pulse only on a real sleep exit; ram is lost so restart
            coreRestart      <= (state_q == ST_SLEEP) &&
                                leaveSleep;
            coreClkDefault   <= 1'b1;
            modeState        <= state_q;
            sleepPeriphEnable <= (state_q == ST_SLEEP) ?
                                 periphCfg_q[3:0] : 4'h0;
        end
    end
endmodule

// saturating cycle counter; stops at its limit so long waits never wrap
module semm_sat_counter #(
    parameter [31:0] LIMIT = 32'h0000_0001
) (
    input  wire sys_clk,
    input  wire rst_n,
    input  wire clear,
    output wire atLimit
);
    reg [31:0] count_q;

    assign atLimit = (count_q >= LIMIT);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 32'h0000_0000;
        end else if (clear) begin
            count_q <= 32'h0000_0000;
        end else if (!atLimit) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// file: sim/semm_supply_manager_asserts.sv
// checker for the supply event and mode manager
`timescale 1ns/1ps
`default_nettype none
module semm_supply_manager_asserts (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       mainSupplyLow,
    input wire logic       wakeEvent,
    input wire logic       supplyIrqGlobalEnable,
    input wire logic       supplyIrq,
    input wire logic       supplySourceMain,
    input wire logic       frontEndEnable,
    input wire logic       coreEnable,
    input wire logic       coreClkDefault,
    input wire logic [2:0] modeState,
    input wire logic [3:0] sleepPeriphEnable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_mode_one_hot: assert property ($onehot(modeState))
        else $error("mode state not one-hot");
    chk_source_tracks_mode: assert property (supplySourceMain == modeState[0])
        else $error("source status disagrees with mode");
    chk_front_end_normal: assert property (frontEndEnable == modeState[0])
        else $error("front end enable outside normal mode");
    chk_core_sleep_off: assert property (coreEnable == !modeState[2])
        else $error("core enable wrong for sleep state");
    chk_clock_default: assert property (coreClkDefault)
        else $error("default core clock not selected");
    chk_irq_global_gate: assert property (supplyIrq |-> $past(supplyIrqGlobalEnable))
        else $error("interrupt without global enable");
    chk_sleep_peripheral_config_gate: assert property (!modeState[2] |-> sleepPeriphEnable == 4'h0)
        else $error("sleep peripherals enabled while awake");
    chk_sleep_holds: assert property (modeState[2] && !wakeEvent && !$past(wakeEvent)
        && mainSupplyLow && $past(mainSupplyLow) |=> modeState[2])
        else $error("left sleep without wake or restore");
    chk_battery_no_restore: assert property (modeState[1] && mainSupplyLow
        && $past(mainSupplyLow) |=> !modeState[0])
        else $error("restored while main supply low");
    cover property (modeState[2]);
    cover property (supplyIrq);
    cover property ($rose(modeState[1]));
endmodule
bind semm_supply_manager semm_supply_manager_asserts u_semm_supply_manager_asserts (
    .sys_clk, .rst_n, .mainSupplyLow, .wakeEvent, .supplyIrqGlobalEnable, .supplyIrq,
    .supplySourceMain, .frontEndEnable, .coreEnable, .coreClkDefault, .modeState,
    .sleepPeriphEnable);
`default_nettype wire

// file: sim/testbench.sv
// self-checking testbench for the supply event and mode manager
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] T3 = 32'h0000_0014;
    localparam logic [31:0] T4 = 32'h0000_0028;
    logic       sys_clk, rst_n, sfrWrEn, sfrRdEn, dcInputLow, mainSupplyLow, wakeEvent;
    logic       lineDipEvent, frontEndPowerDown, supplyIrqGlobalEnable, sleepRequest;
    logic       resultStrobe, supplyIrq, supplySourceMain, frontEndEnable, coreEnable;
    logic       coreRestart, coreClkDefault, sawRestart;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, rdVal;
    logic [7:0] tempResultIn = 8'h11, batResultIn = 8'h22, dcinResultIn = 8'h33;
    logic [2:0] modeState;
    logic [3:0] sleepPeriphEnable;
    int         badCount, comparisons, n;
    semm_supply_manager #(.T3_CYCLES(T3), .T4_CYCLES(T4)) u_semm_supply_manager (
        .sys_clk, .rst_n, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData,
        .dcInputLow, .mainSupplyLow, .lineDipEvent, .frontEndPowerDown,
        .supplyIrqGlobalEnable, .sleepRequest, .wakeEvent, .tempResultIn,
        .batResultIn, .dcinResultIn, .resultStrobe, .supplyIrq, .supplySourceMain,
        .frontEndEnable, .coreEnable, .coreRestart, .coreClkDefault, .modeState,
        .sleepPeriphEnable);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // pulse is one cycle wide, so catch it here
    always @(posedge sys_clk) if (coreRestart === 1'b1) sawRestart <= 1'b1;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrEn <= 1'b1;
        @(posedge sys_clk);
        sfrWrEn <= 1'b0;
    endtask
    // data stands until the next read, so the third edge sees it settled
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge sys_clk);
        sfrRdEn <= 1'b0;
        @(posedge sys_clk);
        rdVal = sfrRdData;
    endtask
    task automatic waitMode(input logic [2:0] exp, input int limit);
        n = 0;
        while (modeState !== exp && n < limit) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {sfrWrEn, sfrRdEn, dcInputLow, mainSupplyLow, lineDipEvent, wakeEvent} = '0;
        {frontEndPowerDown, supplyIrqGlobalEnable, sleepRequest, resultStrobe} = '0;
        {sfrAddr, sfrWrData, sawRestart, badCount, comparisons} = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) wr(8'hfb + 8'(i), 8'ha0 + 8'(i));
        for (int i = 0; i < 4; i++) begin
            rd(8'hfb + 8'(i));
            chk("scratch", rdVal, 8'ha0 + 8'(i));
        end
        rd(8'h42);
        chk("unmapped", rdVal, 8'h00);
        $display("register test done");
        wr(8'hf5, 8'h00);
        wr(8'hec, 8'h21);
        supplyIrqGlobalEnable <= 1'b1;
        dcInputLow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        dcInputLow <= 1'b0;
        rd(8'hf8);
        chk("dc flag", rdVal, 8'h01);
        chk("irq on", {7'h00, supplyIrq}, 8'h01);
        chk("no dc switch", {5'h00, modeState}, 8'h01);
        supplyIrqGlobalEnable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("irq global", {7'h00, supplyIrq}, 8'h00);
        supplyIrqGlobalEnable <= 1'b1;
        wr(8'hec, 8'h20);
        rd(8'hf8);
        chk("flag latched", rdVal, 8'h01);
        chk("irq masked", {7'h00, supplyIrq}, 8'h00);
        wr(8'hf8, 8'hfe);
        rd(8'hf8);
        chk("flag clear", rdVal, 8'h00);
        lineDipEvent <= 1'b1;
        @(posedge sys_clk);
        lineDipEvent <= 1'b0;
        rd(8'hf8);
        chk("dip flag", rdVal, 8'h20);
        chk("dip irq", {7'h00, supplyIrq}, 8'h01);
        wr(8'hfc, 8'h3c);
        $display("event flag test done");
        wr(8'hf4, 8'h05);
        wr(8'hf5, 8'h02);
        mainSupplyLow <= 1'b1;
        repeat (30) @(posedge sys_clk);
        chk("select 10", {5'h00, modeState}, 8'h01);
        wr(8'hf5, 8'h00);
        waitMode(3'b010, 6);
        chk("to battery", {5'h00, modeState}, 8'h02);
        chk("front end", {7'h00, frontEndEnable}, 8'h00);
        rd(8'hf4);
        chk("source bit", rdVal, 8'h05);
        mainSupplyLow <= 1'b0;
        frontEndPowerDown <= 1'b1;
        repeat (T4 + 10) @(posedge sys_clk);
        chk("power down", {5'h00, modeState}, 8'h02);
        frontEndPowerDown <= 1'b0;
        waitMode(3'b001, T4 + 10);
        chk("restore", {5'h00, modeState}, 8'h01);
        chk("source main", {7'h00, supplySourceMain}, 8'h01);
        chk("clock default", {7'h00, coreClkDefault}, 8'h01);
        $display("switchover test done");
        mainSupplyLow <= 1'b1;
        resultStrobe <= 1'b1;
        wr(8'hfb, 8'h5a);
        resultStrobe <= 1'b0;
        waitMode(3'b010, 6);
        sleepRequest <= 1'b1;
        waitMode(3'b100, 10);
        sleepRequest <= 1'b0;
        chk("sleep", {4'h0, sleepPeriphEnable}, 8'h05);
        chk("core off", {7'h00, coreEnable}, 8'h00);
        wr(8'hfb, 8'h00);
        repeat (50) @(posedge sys_clk);
        chk("stay asleep", {5'h00, modeState}, 8'h04);
        wakeEvent <= 1'b1;
        @(posedge sys_clk);
        wakeEvent <= 1'b0;
        waitMode(3'b010, 10);
        chk("restart", {7'h00, sawRestart}, 8'h01);
        wr(8'hec, 8'h20);
        rd(8'hfb);
        chk("scratch kept", rdVal, 8'h5a);
        rd(8'hdf);
        chk("result kept", rdVal, 8'h22);
        rd(8'hf4);
        chk("peripheral_config kept", rdVal, 8'h05);
        sleepRequest <= 1'b1;
        waitMode(3'b100, 10);
        sleepRequest <= 1'b0;
        sawRestart <= 1'b0;
        frontEndPowerDown <= 1'b1;
        mainSupplyLow <= 1'b0;
        repeat (T4 + 10) @(posedge sys_clk);
        chk("held asleep", {7'h00, sawRestart}, 8'h00);
        chk("pd asleep", {5'h00, modeState}, 8'h04);
        frontEndPowerDown <= 1'b0;
        waitMode(3'b001, T4 + 10);
        chk("restore wake", {7'h00, sawRestart}, 8'h01);
        chk("sleep restore", {5'h00, modeState}, 8'h01);
        $display("sleep test done");
        wr(8'hf5, 8'h01);
        dcInputLow <= 1'b1;
        repeat (T3 / 2) @(posedge sys_clk);
        chk("dc early", {5'h00, modeState}, 8'h01);
        waitMode(3'b010, T3 + 10);
        chk("dc switch", {5'h00, modeState}, 8'h02);
        $display("dc switchover test done");
        wrapUp();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        badCount++;
        wrapUp();
    end
endmodule
`default_nettype wire
